// File: include/pwm_pkg.sv
// Package with register map, field layout and reset values of the single output PWM block.
package pwm_pkg;
    // Byte addresses of the word-aligned registers on the APB slave.
    localparam logic [7:0] addr_duty_upper_byte = 8'h00;
    localparam logic [7:0] addr_duty_shadow_byte = 8'h04;
    localparam logic [7:0] addr_unit_control = 8'h08;
    localparam logic [7:0] addr_period_register = 8'h0c;
    localparam logic [7:0] addr_period_timer = 8'h10;
    localparam logic [7:0] addr_period_timer_control = 8'h14;
    localparam logic [7:0] addr_pin_direction = 8'h18;

    // Field positions inside unit_control.
    localparam int duty_low_pos = 4;
    localparam int mode_upper_pos = 2;

    // Field positions inside period_timer_control.
    localparam int timer_on_pos = 2;
    localparam int postscale_pos = 3;

    // Values after reset.
    localparam logic [7:0] rst_byte = 8'h00;
    localparam logic [7:0] rst_period_register = 8'hff;
    localparam logic rst_pin_direction = 1'b1;

    // Mode select upper bits that pick PWM operation.
    localparam logic [1:0] mode_upper_pwm = 2'b11;

    // Prescaler selection codes and the fine count width.
    localparam logic [1:0] presc_div1 = 2'b00;
    localparam logic [1:0] presc_div4 = 2'b01;
    localparam int presc_width = 4;
    localparam int quarter_width = 2;

    // Prescaler phases of the three division factors (factor minus one).
    localparam logic [3:0] presc_last_div1 = 4'h0;
    localparam logic [3:0] presc_last_div4 = 4'h3;
    localparam logic [3:0] presc_last_div16 = 4'hf;
endpackage

// File: rtl/quarter_clock.sv
// Internal quarter-cycle clock: one increment strobe every four oscillator periods.
`timescale 1ns/1ps
module quarter_clock
    import pwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [1:0] phase_o,
    output logic tick_o
);
    // Free-running two-bit phase counter, wraps every four clocks.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_o <= 2'h0;
        end
        else
        begin
            phase_o <= phase_o + 2'h1;
        end
    end

    // The instruction cycle ends on the last quarter.
    assign tick_o = (phase_o == 2'h3);
endmodule

// File: rtl/timer_prescaler.sv
// Period timer prescaler dividing the instruction-cycle strobe by one, four or sixteen.
`timescale 1ns/1ps
module timer_prescaler
    import pwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [1:0] select_i,
    output logic [3:0] count_o,
    output logic inc_o
);
    logic [3:0] last;

    // Selected division factor minus one; both codes 1x divide by sixteen.
    always_comb
    begin
        case (select_i)
            presc_div1: last = presc_last_div1;
            presc_div4: last = presc_last_div4;
            default: last = presc_last_div16;
        endcase
    end

    // Counter is cleared while the timer is off so each start is clean.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            count_o <= 4'h0;
        end
        else if (tick_i)
        begin
            count_o <= (count_o >= last) ? 4'h0 : count_o + 4'h1;
        end
    end

    assign inc_o = run_i && tick_i && (count_o >= last);
endmodule

// File: rtl/single_output_pwm.sv
// Single output PWM unit with period timer, double-buffered duty value and APB registers.
// Operation
// (RULE1) Output pin carries up to 10-bit PWM.
// (RULE2) Software clears direction bit to drive pin.
// (RULE3) Zero control register forces output latch low.
// (RULE4) Period register sets PWM period.
// (RULE5) Timer clears after matching period register.
// (RULE6) Pin set at period start unless 0%.
// (RULE7) Duty copied to shadow at boundary.
// (RULE8) Postscaler does not affect PWM frequency.
// (RULE9) Duty byte high, control bits 5:4 low.
// (RULE10) High time equals duty times prescaled oscillator.
// (RULE11) Duty writes anytime, used next period.
// (RULE12) Shadow byte read-only in PWM mode.
// (RULE13) Shadow plus 2-bit latch double-buffer duty.
// (RULE14) Clear output when shadow matches extended timer.
// (RULE15) Duty beyond period never clears output.
// (RULE16) Prescaler divides by one, four, sixteen.
// (RULE17) Period is (register+1) times 4 times prescale.
// (RULE18) Mode upper bits 11 select PWM.
// (RULE19) Software sets registers in documented order.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module single_output_pwm
    import pwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic pwm_o,
    output logic pwm_oe_n_o,
    output logic period_match_o
);
    logic [7:0] duty_upper_byte;
    logic [7:0] duty_shadow_byte;
    logic [1:0] duty_shadow_low;
    logic [7:0] unit_control;
    logic [7:0] period_register;
    logic [7:0] period_timer;
    logic [6:0] period_timer_control;
    logic pin_direction_bit;
    logic output_latch;
    logic [3:0] postscale_count;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic pwm_mode;
    logic timer_run;
    logic [1:0] q_phase;
    logic q_tick;
    logic [3:0] presc_count;
    logic timer_inc;
    logic at_period;
    logic period_start;
    logic [9:0] duty_next;
    logic [9:0] duty_active;
    logic [1:0] fine_bits;
    logic [9:0] timer_extended;
    logic duty_match;
    logic fine_step;
    logic [9:0] next_extended;
    logic [31:0] next_prdata;

    // APB access decode; every access completes in its first access cycle.
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;
    assign pready_o = 1'b1;

    // Only the seven word addresses of the map are decoded; anything else answers with an error.
    always_comb
    begin
        case (paddr_i)
            addr_duty_upper_byte: addr_ok = 1'h1;
            addr_duty_shadow_byte: addr_ok = 1'h1;
            addr_unit_control: addr_ok = 1'h1;
            addr_period_register: addr_ok = 1'h1;
            addr_period_timer: addr_ok = 1'h1;
            addr_period_timer_control: addr_ok = 1'h1;
            addr_pin_direction: addr_ok = 1'h1;
            default: addr_ok = 1'h0;
        endcase
    end
    assign pslverr_o = psel_i && penable_i && !addr_ok;

    // (RULE18) PWM mode select
    assign pwm_mode = (unit_control[mode_upper_pos +: 2] == mode_upper_pwm);
    assign timer_run = period_timer_control[timer_on_pos];

    // Instruction-cycle strobe that also supplies the two fine duty bits at divide by one.
    quarter_clock u_quarter_clock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phase_o(q_phase),
        .tick_o(q_tick)
    );

    // (RULE16) Prescaler one four sixteen
    timer_prescaler u_timer_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(timer_run),
        .tick_i(q_tick),
        .select_i(period_timer_control[1:0]),
        .count_o(presc_count),
        .inc_o(timer_inc)
    );

    // (RULE5) Match clears on next increment
    assign at_period = (period_timer == period_register);
    assign period_start = timer_inc && at_period;
    assign period_match_o = period_start;

    // Period timer; a software write loads it directly.
    // (RULE4) Period from period register
    // (RULE17) Period is register plus one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            period_timer <= rst_byte;
        end
        else if (wr_en && paddr_i == addr_period_timer)
        begin
            period_timer <= pwdata_i[7:0];
        end
        else if (period_start)
        begin
            period_timer <= rst_byte;
        end
        else if (timer_inc)
        begin
            period_timer <= period_timer + 8'h01;
        end
    end

    // (RULE8) Postscaler counts only, never steers period
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            postscale_count <= 4'h0;
        end
        else if (period_start)
        begin
            postscale_count <= (postscale_count == period_timer_control[postscale_pos +: 4]) ?
                4'h0 : postscale_count + 4'h1;
        end
    end

    // Duty byte; software may rewrite it at any time because the output reads it only at the period boundary, when the shadow copy loads.
    // (RULE11) Duty writes accepted anytime
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            duty_upper_byte <= rst_byte;
        end
        else if (wr_en && paddr_i == addr_duty_upper_byte)
        begin
            duty_upper_byte <= pwdata_i[7:0];
        end
    end

    // Control byte; the two top bits are not implemented and read as zero.
    // (RULE11) Low duty bits accepted anytime
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unit_control <= rst_byte;
        end
        else if (wr_en && paddr_i == addr_unit_control)
        begin
            unit_control <= {2'h0, pwdata_i[5:0]};
        end
    end

    // Period register; a new value takes part in the very next comparison with the timer.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            period_register <= rst_period_register;
        end
        else if (wr_en && paddr_i == addr_period_register)
        begin
            period_register <= pwdata_i[7:0];
        end
    end

    // Timer control: prescaler select, run bit and postscaler field.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            period_timer_control <= 7'h00;
        end
        else if (wr_en && paddr_i == addr_period_timer_control)
        begin
            period_timer_control <= pwdata_i[6:0];
        end
    end

    // Direction bit; it leaves reset set so the pin stays released until software claims it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_direction_bit <= rst_pin_direction;
        end
        else if (wr_en && paddr_i == addr_pin_direction)
        begin
            pin_direction_bit <= pwdata_i[0];
        end
    end

    // (RULE9) Ten-bit duty composition
    assign duty_next = {duty_upper_byte, unit_control[duty_low_pos +: 2]};

    // Shadow byte and hidden low latch; in PWM mode loading only at the boundary avoids mid-period glitches.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            duty_shadow_byte <= rst_byte;
            duty_shadow_low <= 2'b00;
        end
        // (RULE7) Latch duty at boundary
        // (RULE13) Shadow double-buffer
        else if (pwm_mode && period_start)
        begin
            duty_shadow_byte <= duty_next[9:2];
            duty_shadow_low <= duty_next[1:0];
        end
        // (RULE12) Shadow read-only in PWM
        else if (!pwm_mode && wr_en && paddr_i == addr_duty_shadow_byte)
        begin
            duty_shadow_byte <= pwdata_i[7:0];
        end
    end
    assign duty_active = {duty_shadow_byte, duty_shadow_low};

    // Fine bits count in the unit of one prescaled clock, so one duty step is one prescaled oscillator period.
    // At divide by sixteen the low prescaler bits only pace the fine bits, which step every fourth tick.
    // (RULE14) Extended timer comparison
    always_comb
    begin
        case (period_timer_control[1:0])
            presc_div1:
            begin
                fine_bits = q_phase;
                fine_step = 1'h1;
            end
            presc_div4:
            begin
                fine_bits = presc_count[1:0];
                fine_step = q_tick;
            end
            default:
            begin
                fine_bits = presc_count[3:2];
                fine_step = q_tick && (presc_count[1:0] == 2'h3);
            end
        endcase
    end
    assign timer_extended = {period_timer, fine_bits};
    assign next_extended = timer_extended + 10'h001;

    // The latch is a register, so it is cleared on the edge that moves the count onto the duty value;
    // comparing the present count instead would stretch every pulse by one duty step.
    assign duty_match = fine_step && (duty_active == next_extended);

    // Output latch; a stale duty above the period is never matched so the pin stays high.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            output_latch <= 1'b0;
        end
        // (RULE3) Zero control forces low
        else if (unit_control == rst_byte)
        begin
            output_latch <= 1'b0;
        end
        else if (!pwm_mode)
        begin
            output_latch <= 1'b0;
        end
        // (RULE6) Set at start unless 0%
        else if (period_start)
        begin
            output_latch <= (duty_next != 10'h000);
        end
        // (RULE10) High time from duty
        // (RULE15) Overlong duty never clears
        else if (timer_run && duty_match)
        begin
            output_latch <= 1'b0;
        end
    end

    // (RULE1) Pin output
    // (RULE2) Direction bit gates drive
    assign pwm_o = output_latch;
    assign pwm_oe_n_o = pin_direction_bit;

    // Read mux, registered so read data is stable in the access phase's following cycle.
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr_i)
            addr_duty_upper_byte: next_prdata[7:0] = duty_upper_byte;
            addr_duty_shadow_byte: next_prdata[7:0] = duty_shadow_byte;
            addr_unit_control: next_prdata[7:0] = unit_control;
            addr_period_register: next_prdata[7:0] = period_register;
            addr_period_timer: next_prdata[7:0] = period_timer;
            addr_period_timer_control: next_prdata[6:0] = period_timer_control;
            addr_pin_direction: next_prdata[0] = pin_direction_bit;
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // Data is captured in the setup cycle so it is valid during the access phase.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prdata_o <= 32'h0000_0000;
        end
        else if (psel_i && !penable_i && !pwrite_i)
        begin
            prdata_o <= next_prdata;
        end
        else if (rd_en)
        begin
            prdata_o <= prdata_o;
        end
    end
endmodule

// File: sim/pwm_load_model.sv
// External load on the PWM pin that measures high time and period in clock cycles.
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic clk_i,
    input wire logic pin_i,
    output int high_len_o,
    output int period_len_o,
    output int rises_o
);
    int hi_cnt = 0;
    int per_cnt = 0;
    logic last = 1'b0;
    initial
    begin
        rises_o = 0;
    end
    // A passive load only listens; the pin level already includes the pull-down when undriven.
    // released pin low
    always @(posedge clk_i)
    begin
        last <= pin_i;
        hi_cnt <= pin_i ? hi_cnt + 1 : 0;
        per_cnt <= (pin_i && !last) ? 1 : per_cnt + 1;
        if (pin_i && !last)
        begin
            rises_o <= rises_o + 1;
            period_len_o <= per_cnt;
        end
        if (!pin_i && last)
            high_len_o <= hi_cnt;
    end
endmodule

// File: sim/single_output_pwm_sva.sv
// Port checker for the single output PWM block.
`timescale 1ns/1ps
module single_output_pwm_sva
    import pwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic pwm_o,
    input wire logic pwm_oe_n_o,
    input wire logic period_match_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Completed writes decoded once, shared by several checks.
    wire logic wr = psel_i && penable_i && pwrite_i;
    wire logic dir_wr = wr && paddr_i == addr_pin_direction;
    a_ready_high: assert property (psel_i |-> pready_o)
        else $error("pready low during a transfer");
    a_err_decode: assert property (psel_i && penable_i && paddr_i[1:0] == 2'b00
        |-> pslverr_o == (paddr_i > addr_pin_direction))
        else $error("pslverr does not match the address map");
    a_read_stable: assert property (psel_i && penable_i |=> $stable(prdata_o))
        else $error("read data moved right after the access");
    a_rise_boundary: assert property ($rose(pwm_o) |-> $past(period_match_o))
        else $error("output rose away from a period boundary");
    a_match_spacing: assert property (period_match_o |=> !period_match_o [*3])
        else $error("period boundaries closer than four clocks");
    a_mode_off_low: assert property (wr && paddr_i == addr_unit_control
        && pwdata_i[3:2] != mode_upper_pwm |-> ##2 !pwm_o [*2])
        else $error("output not low with PWM mode off");
    a_dir_write: assert property (dir_wr |=> pwm_oe_n_o == $past(pwdata_i[0]))
        else $error("output enable does not follow direction write");
    a_dir_hold: assert property (!dir_wr |=> $stable(pwm_oe_n_o))
        else $error("output enable changed without a write");
endmodule

// File: sim/test_single_output_pwm.sv
// Self-checking bench for the single output PWM block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
bind single_output_pwm single_output_pwm_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o),
    .period_match_o(period_match_o));
module test_single_output_pwm
    import pwm_pkg::*;
    ;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, pwm_o, pwm_oe_n_o, period_match_o, err;
    int fail_count = 0;
    int n_compared = 0;
    int high_len, period_len, rises, n;
    typedef struct {logic [7:0] tcon; logic [7:0] pr; logic [9:0] duty; int hi; int per;} row_t;
    // Timer control, period, duty, then expected high time and period; row two runs a nonzero postscale.
    row_t rows[5] = '{'{8'h04, 8'h03, 10'h005, 5, 16}, '{8'h7d, 8'h02, 10'h008, 32, 48},
        '{8'h06, 8'h01, 10'h006, 96, 128}, '{8'h07, 8'h00, 10'h002, 32, 64}, '{8'h04, 8'h00, 10'h003, 3, 4}};
    // Undriven pin falls to the pull-down level.
    wire logic pin = pwm_oe_n_o ? 1'b0 : pwm_o;
    single_output_pwm u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o), .period_match_o(period_match_o));
    pwm_load_model u_load (.clk_i(clk_i), .pin_i(pin), .high_len_o(high_len), .period_len_o(period_len),
        .rises_o(rises));
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic summarize();
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
            @(posedge clk_i);
        while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wait_rises(input int k);
        int r0;
        r0 = rises;
        while (rises < r0 + k)
            @(posedge clk_i);
    endtask
    task automatic setup(input logic [7:0] tcon, input logic [7:0] pr, input logic [9:0] duty);
        apb(1'b1, addr_period_register, {24'h0, pr});
        apb(1'b1, addr_duty_upper_byte, {24'h0, duty[9:2]});
        apb(1'b1, addr_pin_direction, 32'h0);
        apb(1'b1, addr_period_timer_control, {24'h0, tcon});
        apb(1'b1, addr_unit_control, {26'h0, duty[1:0], 4'hc});
    endtask
    // Watchdog sized well above the longest expected run.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            apb(1'b1, addr_period_timer_control, 32'h0);
            apb(1'b1, addr_period_timer, 32'h0);
            setup(rows[i].tcon, rows[i].pr, rows[i].duty);
            wait_rises(3);
            `CHK("period", rows[i].per, period_len)
            `CHK("high time", rows[i].hi, high_len)
            apb(1'b0, addr_duty_shadow_byte, 32'h0);
            `CHK("shadow", {24'h0, rows[i].duty[9:2]}, rd)
            apb(1'b1, addr_duty_shadow_byte, 32'h5a);
            apb(1'b0, addr_duty_shadow_byte, 32'h0);
            `CHK("shadow kept", {24'h0, rows[i].duty[9:2]}, rd)
            apb(1'b1, addr_unit_control, 32'h0);
            repeat (3) @(posedge clk_i);
            `CHK("pin off", 1'b0, pwm_o)
        end
        // A zero duty must never raise the pin, then a new duty lands mid-period.
        n = rises;
        setup(8'h04, 8'h03, 10'h000);
        repeat (40) @(posedge clk_i);
        `CHK("zero duty", n, rises)
        apb(1'b1, addr_duty_upper_byte, 32'h02);
        apb(1'b1, addr_unit_control, 32'h1c);
        wait_rises(3);
        `CHK("new duty", 9, high_len)
        apb(1'b1, addr_duty_upper_byte, 32'hff);
        apb(1'b1, addr_unit_control, 32'h3c);
        wait_rises(1);
        n = rises;
        repeat (40) @(posedge clk_i);
        `CHK("long duty", n, rises)
        `CHK("long duty pin", 1'b1, pwm_o)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK("reset pin", 1'b0, pwm_o)
        `CHK("reset enable", 1'b1, pwm_oe_n_o)
        apb(1'b0, addr_period_register, 32'h0);
        `CHK("reset period", 32'hff, rd)
        apb(1'b0, addr_unit_control, 32'h0);
        `CHK("reset control", 32'h0, rd)
        summarize();
    end
endmodule
